//--- verilog/period_pkg.sv
package period_pkg;
  // ==========================================================
  // counts and widths
  localparam int unsigned TIMER_W = 24;
  localparam int unsigned LONG_RUN = 63;
  localparam int unsigned SHORT_TOTAL = 32;
  localparam int unsigned COUNT_W = 6;
  // default qualifying intervals in microseconds
  localparam int unsigned ENABLE_QUALIFY_US = 20;
  localparam int unsigned DISABLE_QUALIFY_US = 40;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned ENABLE_QUALIFY_CYC = ENABLE_QUALIFY_US * CLK_MHZ;
  localparam int unsigned DISABLE_QUALIFY_CYC = DISABLE_QUALIFY_US * CLK_MHZ;
  // alert pulse timing, 33 kHz repeat, short pulse
  localparam int unsigned ALERT_PERIOD_NS = 30303;
  localparam int unsigned ALERT_PERIOD_CYC = ALERT_PERIOD_NS / 5;
  localparam int unsigned ALERT_PULSE_NS = 200;
  localparam int unsigned ALERT_PULSE_CYC = ALERT_PULSE_NS / 5;
  // ==========================================================
  // operating modes of the enable output
  typedef enum logic {
    MODE_RELEASED = 1'b0,
    MODE_PULLED = 1'b1
  } mode_t;
endpackage

//--- verilog/cycle_if.sv
`timescale 1ns/1ps
// ==========================================================
// interval classification passed to the counter
interface cycle_if;
  logic cycle_p; // one-cycle pulse per detected power cycle
  logic is_short; // interval below enable qualifying
  logic is_long; // interval above disable qualifying
  modport src (output cycle_p, output is_short, output is_long);
  modport dst (input cycle_p, input is_short, input is_long);
endinterface

//--- verilog/period_timer.sv
`timescale 1ns/1ps
// ==========================================================
// free-running interval timer and classifier
module period_timer #(
  parameter int unsigned TW = period_pkg::TIMER_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cycle_seen,
  input wire logic [TW-1:0] enable_qualify_interval,
  input wire logic [TW-1:0] disable_qualify_interval,
  cycle_if.src cyc
);
  logic [TW-1:0] timer_q; // cycles since last power cycle
  logic [TW-1:0] timer_d;
  logic sat_w; // timer saturated
  assign sat_w = &timer_q;
  // restart on each cycle, saturate otherwise
  assign timer_d = cycle_seen ? {{(TW-1){1'b0}}, 1'b1} : (sat_w ? timer_q : timer_q + 1'b1);
  // classification of the interval just ended
  assign cyc.cycle_p = cycle_seen;
  assign cyc.is_short = timer_q < enable_qualify_interval;
  assign cyc.is_long = timer_q > disable_qualify_interval;
  // ==========================================================
  // timer register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_q <= '0;
    end
    else
    begin
      timer_q <= timer_d;
    end
  end
endmodule

//--- verilog/switching_period_enable_counter.sv
`timescale 1ns/1ps
// ==========================================================
// enable/disable hysteresis counter with droop alert
module switching_period_enable_counter #(
  parameter int unsigned TW = period_pkg::TIMER_W,
  parameter int unsigned ALERT_PERIOD = period_pkg::ALERT_PERIOD_CYC,
  parameter int unsigned ALERT_PULSE = period_pkg::ALERT_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic power_cycle_detect,
  input wire logic demag_end,
  input wire logic supply_below_reference,
  input wire logic undervoltage,
  input wire logic [TW-1:0] enable_qualify_interval,
  input wire logic [TW-1:0] disable_qualify_interval,
  output logic secondary_disable_output_o,
  output logic secondary_disable_output_oe,
  output logic reference_refresh,
  output logic alert_o,
  output logic alert_oe
);
  // ==========================================================
  // reset release
  logic rst_s1_q; // first reset stage
  logic rst_n_q; // released reset
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ==========================================================
  // pin synchronisers
  logic [3:0] sync1_q; // first stage only feeds second
  logic [3:0] sync2_q; // safe copies
  logic [3:0] pins_w;
  assign pins_w = {undervoltage, supply_below_reference, demag_end, power_cycle_detect};
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= pins_w;
      sync2_q <= sync1_q;
    end
  end
  logic pcd_s, demag_s, droop_s, uv_s;
  assign pcd_s = sync2_q[0];
  assign demag_s = sync2_q[1];
  assign droop_s = sync2_q[2];
  assign uv_s = sync2_q[3];

  // ==========================================================
  // edge detection on synchronised levels
  logic pcd_old_q; // previous cycle detect
  logic demag_old_q; // previous demag end
  logic cycle_seen; // rising edge of cycle detect
  logic demag_rise; // rising edge of demag end
  assign cycle_seen = pcd_s & ~pcd_old_q;
  assign demag_rise = demag_s & ~demag_old_q;
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pcd_old_q <= 1'b0;
      demag_old_q <= 1'b0;
    end
    else
    begin
      pcd_old_q <= pcd_s;
      demag_old_q <= demag_s;
    end
  end

  // ==========================================================
  // interval timer
  cycle_if cyc ();
  period_timer #(.TW(TW)) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n_q),
    .cycle_seen(cycle_seen),
    .enable_qualify_interval(enable_qualify_interval),
    .disable_qualify_interval(disable_qualify_interval),
    .cyc(cyc)
  );

  // ==========================================================
  // mode and counters
  period_pkg::mode_t mode_q, mode_d; // enable output mode
  logic [period_pkg::COUNT_W-1:0] long_q, long_d; // consecutive long periods
  logic [period_pkg::COUNT_W-1:0] short_q, short_d; // cumulative short periods
  localparam logic [period_pkg::COUNT_W-1:0] LONG_LAST = 6'(period_pkg::LONG_RUN - 1);
  localparam logic [period_pkg::COUNT_W-1:0] SHORT_LAST = 6'(period_pkg::SHORT_TOTAL - 1);
  logic go_low, go_high;
  assign go_low = (mode_q == period_pkg::MODE_RELEASED) && cyc.cycle_p && cyc.is_long
                  && (long_q == LONG_LAST);
  assign go_high = (mode_q == period_pkg::MODE_PULLED) && cyc.cycle_p && cyc.is_short
                   && (short_q >= SHORT_LAST);

  // next state; droop alert plays no part here
  always_comb
  begin
    mode_d = mode_q;
    long_d = long_q;
    short_d = short_q;
    unique case (mode_q)
      period_pkg::MODE_RELEASED:
      begin
        // stays released while periods not long
        if (cyc.cycle_p)
        begin
          if (!cyc.is_long)
          begin
            long_d = '0;
          end
          else if (go_low)
          begin
            mode_d = period_pkg::MODE_PULLED;
            long_d = '0;
            short_d = '0;
          end
          else
          begin
            long_d = long_q + 1'b1;
          end
        end
      end
      period_pkg::MODE_PULLED:
      begin
        // long periods do not clear the cumulative count
        if (cyc.cycle_p && cyc.is_short)
        begin
          if (go_high)
          begin
            mode_d = period_pkg::MODE_RELEASED;
            short_d = '0;
          end
          else
          begin
            short_d = short_q + 1'b1;
          end
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mode_q <= period_pkg::MODE_RELEASED;
      long_q <= '0;
      short_q <= '0;
    end
    else
    begin
      mode_q <= mode_d;
      long_q <= long_d;
      short_q <= short_d;
    end
  end

  // open-drain enable output, driven low only when pulled
  assign secondary_disable_output_o = 1'b0;
  assign secondary_disable_output_oe = (mode_q == period_pkg::MODE_PULLED);

  // ==========================================================
  // droop reference refresh strobe
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      reference_refresh <= 1'b0;
    end
    else
    begin
      reference_refresh <= demag_rise;
    end
  end

  // ==========================================================
  // droop alert pulse generator
  logic alert_act_q, alert_act_d; // alert train running
  logic [15:0] alert_cnt_q, alert_cnt_d; // position in repeat period
  logic pulse_q; // registered pulse drive
  logic alert_stop;
  assign alert_stop = cycle_seen | uv_s;
  // start in either mode on droop, stop on cycle or undervoltage
  always_comb
  begin
    alert_act_d = alert_act_q;
    alert_cnt_d = alert_cnt_q;
    if (alert_stop)
    begin
      alert_act_d = 1'b0;
      alert_cnt_d = '0;
    end
    else if (!alert_act_q && droop_s)
    begin
      alert_act_d = 1'b1;
      alert_cnt_d = '0;
    end
    else if (alert_act_q)
    begin
      alert_cnt_d = (alert_cnt_q == 16'(ALERT_PERIOD - 1)) ? '0 : alert_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      alert_act_q <= 1'b0;
      alert_cnt_q <= '0;
      pulse_q <= 1'b0;
    end
    else
    begin
      alert_act_q <= alert_act_d;
      alert_cnt_q <= alert_cnt_d;
      pulse_q <= alert_act_d && (alert_cnt_d < 16'(ALERT_PULSE));
    end
  end

  assign alert_o = 1'b0;
  assign alert_oe = pulse_q;
endmodule

//--- bench/period_partner.sv
`timescale 1ns/1ps
// ==========================================================
// regulator model: power cycles with demag ends
module period_partner (
  input wire logic sys_clk,
  output logic power_cycle_detect,
  output logic demag_end
);
  // lines rest low between cycles
  initial
  begin
    power_cycle_detect = 1'b0;
    demag_end = 1'b0;
  end
  // n cycles, each ending an interval of p clocks
  task automatic burst(input int n, input int p);
    repeat (n)
    begin
      repeat (p - 4) @(posedge sys_clk);
      power_cycle_detect <= 1'b1;
      repeat (2) @(posedge sys_clk);
      power_cycle_detect <= 1'b0;
      demag_end <= 1'b1;
      repeat (2) @(posedge sys_clk);
      demag_end <= 1'b0;
    end
  endtask
endmodule

//--- bench/switching_period_enable_counter_sva.sv
`timescale 1ns/1ps
// ==========================================================
// port checks of the enable counter
module switching_period_enable_counter_sva #(
  parameter int unsigned ALERT_PULSE = period_pkg::ALERT_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic power_cycle_detect,
  input wire logic demag_end,
  input wire logic supply_below_reference,
  input wire logic undervoltage,
  input wire logic secondary_disable_output_o,
  input wire logic secondary_disable_output_oe,
  input wire logic reference_refresh,
  input wire logic alert_o,
  input wire logic alert_oe
);
  logic [7:0] high_q; // alert pulse length
  logic [5:0] pc_q; // recent cycle pin samples
  // pulse length and cycle history
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      high_q <= 8'h00;
      pc_q <= 6'h00;
    end
    else
    begin
      high_q <= alert_oe ? high_q + 8'h01 : 8'h00;
      pc_q <= {pc_q[4:0], power_cycle_detect};
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  a_od_low: assert property (!secondary_disable_output_o)
    else $error("enable pin driven high");
  a_alert_low: assert property (!alert_o)
    else $error("alert pin driven high");
  a_refresh_once: assert property (reference_refresh |=> !reference_refresh)
    else $error("refresh too long");
  a_refresh_due: assert property ($rose(demag_end) |-> ##[2:6] reference_refresh)
    else $error("refresh missing");
  a_oe_quiet: assert property
    ((!power_cycle_detect) [*8] |=> $stable(secondary_disable_output_oe))
    else $error("enable moved without cycle");
  a_uv_quiet: assert property
    (undervoltage [*8] ##1 undervoltage |-> !alert_oe)
    else $error("alert under undervoltage");
  a_alert_start: assert property
    ($rose(supply_below_reference) && !alert_oe && !undervoltage |-> ##[1:6] alert_oe)
    else $error("alert missing");
  a_alert_width: assert property
    ($fell(alert_oe) && !undervoltage && pc_q == 6'h00 |-> high_q == 8'(ALERT_PULSE))
    else $error("alert width wrong");
  c_pull: cover property ($rose(secondary_disable_output_oe));
  c_free: cover property ($fell(secondary_disable_output_oe));
  c_alert: cover property ($rose(alert_oe));
endmodule
bind switching_period_enable_counter switching_period_enable_counter_sva #(
  .ALERT_PULSE(ALERT_PULSE)
) u_switching_period_enable_counter_sva (
  .sys_clk, .rstn, .power_cycle_detect, .demag_end, .supply_below_reference,
  .undervoltage, .secondary_disable_output_o, .secondary_disable_output_oe,
  .reference_refresh, .alert_o, .alert_oe
);

//--- bench/switching_period_enable_counter_tb.sv
`timescale 1ns/1ps
// ==========================================================
// bench of the enable counter
module switching_period_enable_counter_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic power_cycle_detect;
  logic demag_end;
  logic supply_below_reference = 1'b0;
  logic undervoltage = 1'b0;
  logic secondary_disable_output_oe;
  logic reference_refresh;
  logic alert_oe;
  logic alert_q = 1'b0;
  int failures = 0;
  int n_checks = 0;
  int n_ref = 0;
  int n_alert = 0;
  always #2.5 sys_clk = ~sys_clk;
  // thresholds 50 and 100 clocks, short alert timing
  switching_period_enable_counter #(
    .ALERT_PERIOD(20),
    .ALERT_PULSE(4)
  ) u_switching_period_enable_counter (
    .sys_clk, .rstn, .power_cycle_detect, .demag_end, .supply_below_reference,
    .undervoltage, .enable_qualify_interval(24'h000032),
    .disable_qualify_interval(24'h000064), .secondary_disable_output_o(),
    .secondary_disable_output_oe, .reference_refresh, .alert_o(), .alert_oe
  );
  period_partner u_period_partner (.sys_clk, .power_cycle_detect, .demag_end);
  // counts refreshes and alert starts
  always @(posedge sys_clk)
  begin
    alert_q <= alert_oe;
    n_ref <= n_ref + int'(reference_refresh === 1'b1);
    n_alert <= n_alert + int'(alert_oe === 1'b1 && alert_q === 1'b0);
  end
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic pc(input int n, input int p);
    u_period_partner.burst(n, p);
  endtask
  // settle, then look at the pull-down enable
  task automatic oe_is(input logic exp);
    ticks(6);
    chk("pull enable", 32'(secondary_disable_output_oe), 32'(exp));
  endtask
  // broken long run restarts the count
  task automatic sc_disable;
    oe_is(1'b0);
    pc(71, 30);
    oe_is(1'b0);
    pc(62, 150);
    pc(1, 75);
    pc(62, 150);
    oe_is(1'b0);
    pc(1, 150);
    oe_is(1'b1);
  endtask
  // scattered shorts release, one refresh per cycle
  task automatic sc_release;
    int r;
    pc(20, 30);
    pc(5, 150);
    pc(11, 30);
    oe_is(1'b1);
    r = n_ref;
    pc(3, 75);
    ticks(8);
    chk("refreshes", 32'(n_ref - r), 32'h3);
    pc(1, 30);
    oe_is(1'b0);
  endtask
  // droop mid-run keeps count and mode
  task automatic sc_droop;
    int a;
    pc(40, 150);
    a = n_alert;
    supply_below_reference <= 1'b1;
    ticks(100);
    supply_below_reference <= 1'b0;
    chk("repeats", 32'(n_alert - a >= 4), 32'h1);
    oe_is(1'b0);
    pc(22, 150);
    oe_is(1'b0);
    pc(1, 150);
    oe_is(1'b1);
  endtask
  // alert while pulled, stopped by undervoltage and cycle
  task automatic sc_stop;
    int a;
    a = n_alert;
    supply_below_reference <= 1'b1;
    ticks(30);
    chk("pulled alert", 32'(n_alert > a), 32'h1);
    undervoltage <= 1'b1;
    ticks(12);
    a = n_alert;
    ticks(60);
    chk("uv alerts", 32'(n_alert - a), 32'h0);
    // droop still present: train resumes once undervoltage clears
    undervoltage <= 1'b0;
    a = n_alert;
    ticks(12);
    chk("uv release alert", 32'(n_alert > a), 32'h1);
    // droop gone but train running: a power cycle or undervoltage stops it
    supply_below_reference <= 1'b0;
    pc(1, 30);
    ticks(12);
    a = n_alert;
    ticks(60);
    chk("late alerts", 32'(n_alert - a), 32'h0);
  endtask
  // main sequence
  initial
  begin
    ticks(10);
    rstn <= 1'b1;
    ticks(4);
    sc_disable();
    sc_release();
    sc_droop();
    sc_stop();
    report_and_stop();
  end
  // hang guard
  initial
  begin
    ticks(60000);
    failures++;
    report_and_stop();
  end
endmodule
